// ===== testbench/reset_source_sequencer_assertions.sv
/* Port checker for the reset source sequencer.
   Bound to the design; STARTUP_CYCLES follows the instance. */
`timescale 1ns/100ps
module reset_source_sequencer_assertions
#(
   parameter integer STARTUP_CYCLES = 20
)
(
   input wire       aclk,
   input wire       aresetn,
   input wire       s_axi_awvalid,
   input wire       s_axi_awready,
   input wire       s_axi_wvalid,
   input wire       s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire       s_axi_bvalid,
   input wire       s_axi_bready,
   input wire       s_axi_arvalid,
   input wire       s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire       s_axi_rvalid,
   input wire       s_axi_rready,
   input wire       supply_above_por,
   input wire       pin_reset_n,
   input wire       brownout_detector_enable,
   input wire       comparator_bandgap_select,
   input wire       converter_enable,
   input wire       internal_reset_q,
   input wire       port_reset_q,
   input wire       bandgap_enable_q
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reg [7:0]  pin_lo_q;
   reg [15:0] quiet_q;
   // Counters saturate so a long quiet run never wraps into a false stretch
   always @(posedge aclk)
   begin
      if (!aresetn || pin_reset_n)
         pin_lo_q <= 8'h00;
      else if (pin_lo_q != 8'hff)
         pin_lo_q <= pin_lo_q + 8'h01;
      if (!aresetn || port_reset_q)
         quiet_q <= 16'h0000;
      else if (quiet_q != 16'hffff)
         quiet_q <= quiet_q + 16'h0001;
   end
   property p_wr_resp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_por;
      !supply_above_por |=> port_reset_q && internal_reset_q;
   endproperty
   a_por: assert property (p_por) else $error("supply low without reset");
   property p_pin;
      pin_lo_q >= 8'd18 |-> port_reset_q;
   endproperty
   a_pin: assert property (p_pin) else $error("long pin pulse ignored");
   property p_stretch;
      quiet_q < STARTUP_CYCLES - 1 |-> internal_reset_q;
   endproperty
   a_stretch: assert property (p_stretch) else $error("reset released early");
   property p_release;
      quiet_q == STARTUP_CYCLES + 2 |-> !internal_reset_q;
   endproperty
   a_release: assert property (p_release) else $error("reset held too long");
   property p_band;
      $past(aresetn) |-> bandgap_enable_q ==
         $past(brownout_detector_enable || comparator_bandgap_select || converter_enable);
   endproperty
   a_band: assert property (p_band) else $error("reference power wrong");
   c_pin: cover property (pin_lo_q == 8'd18);
   c_release: cover property (quiet_q == STARTUP_CYCLES + 2);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // reset_source_sequencer_assertions
bind reset_source_sequencer reset_source_sequencer_assertions
   #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .supply_above_por,
   .pin_reset_n, .brownout_detector_enable, .comparator_bandgap_select, .converter_enable,
   .internal_reset_q, .port_reset_q, .bandgap_enable_q);

// ===== testbench/supply_model.sv
/* Model of the reset pin and the supply monitors at the sequencer's far side.
   The bench calls pulse(); lines change just after aclk rising edges. */
`timescale 1ns/100ps
module supply_model
(
   input  wire aclk,
   output reg  supply_above_por,
   output reg  pin_reset_n,
   output reg  vcc_below_low_level,
   output reg  vcc_below_high_level
);
   initial
   begin
      supply_above_por = 1'b1;
      pin_reset_n = 1'b1;
      vcc_below_low_level = 1'b0;
      vcc_below_high_level = 1'b0;
   end
   // Source k (0 supply, 1 pin, 2 low level, 3 high level) set active or inactive by on; n is unused here
   task drop(input integer k, input integer n, input reg on);
      case (k)
         0: supply_above_por <= !on;
         1: pin_reset_n <= !on;
         2: vcc_below_low_level <= on;
         default: vcc_below_high_level <= on;
      endcase
   endtask
   task pulse(input integer k, input integer n);
   begin
      drop(k, n, 1'b1);
      repeat (n) @(posedge aclk);
      drop(k, n, 1'b0);
   end
   endtask
endmodule // supply_model

// ===== testbench/testbench.sv
/* Self-checking bench for the reset source sequencer over AXI4-Lite.
   Uses supply_model on the source side and a short start-up count. */
`timescale 1ns/100ps
module testbench;
   localparam integer SC = 20;
   reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   reg         s_axi_rready, debug_reset_instruction, brownout_level_select, run;
   reg         brownout_detector_enable, comparator_bandgap_select, converter_enable;
   reg         watchdog_osc_tick, watchdog_reset_instr;
   reg  [7:0]  s_axi_awaddr, s_axi_araddr;
   reg  [31:0] s_axi_wdata;
   reg  [3:0]  s_axi_wstrb;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire        internal_reset_q, port_reset_q, bandgap_enable_q;
   wire        supply_above_por, pin_reset_n, vcc_below_low_level, vcc_below_high_level;
   integer     errors, checked, n, i;
   supply_model m (.aclk, .supply_above_por, .pin_reset_n, .vcc_below_low_level,
      .vcc_below_high_level);
   reset_source_sequencer #(.STARTUP_CYCLES(SC), .STARTUP_W(17)) uut (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .supply_above_por, .pin_reset_n, .vcc_below_low_level,
      .vcc_below_high_level, .brownout_level_select, .brownout_detector_enable,
      .debug_reset_instruction, .comparator_bandgap_select, .converter_enable,
      .watchdog_osc_tick, .watchdog_reset_instr, .internal_reset_q, .port_reset_q,
      .bandgap_enable_q);
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // Oscillator tick every second clock keeps expiry well inside the run length
   always @(posedge aclk)
      watchdog_osc_tick <= run & ~watchdog_osc_tick;
   task test_done;
   begin
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask
   task check(input [31:0] seen, input [31:0] exp);
   begin
      checked = checked + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task near(input integer v, input integer lo, input integer hi);
      check({31'h0, v >= lo && v <= hi}, 32'h1);
   endtask
   task wr(input [7:0] a, input [31:0] d, input [1:0] er);
      reg done;
   begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      done = 1'b0;
      for (i = 0; i < 30 && !done; i = i + 1)
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
         begin
            s_axi_bready <= 1'b0;
            done = 1'b1;
            check(s_axi_bresp, er);
         end
      end
      if (!done)
         begin errors = errors + 1; test_done; end
   end
   endtask
   task rdc(input [7:0] a, input [31:0] exp, input [1:0] er);
      reg done;
   begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      done = 1'b0;
      for (i = 0; i < 30 && !done; i = i + 1)
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
         begin
            s_axi_rready <= 1'b0;
            done = 1'b1;
            check(s_axi_rdata, exp);
            check(s_axi_rresp, er);
         end
      end
      if (!done)
         begin errors = errors + 1; test_done; end
   end
   endtask
   // Clocks until the stretched reset drops
   task settle;
   begin
      n = 0;
      while (internal_reset_q !== 1'b0 && n < 200)
         begin @(posedge aclk); n = n + 1; end
      if (n >= 200)
         begin errors = errors + 1; test_done; end
   end
   endtask
   task t_start;
   begin
      settle;
      near(n, SC - 2, SC + 3);
      rdc(8'h00, 32'h1, 2'h0);
      rdc(8'h04, 32'h0, 2'h0);
      rdc(8'h0c, 32'h0, 2'h2);
      wr(8'h0c, 32'hff, 2'h2);
      s_axi_wstrb <= 4'he;
      wr(8'h00, 32'h0, 2'h0);
      rdc(8'h00, 32'h1, 2'h0);
      s_axi_wstrb <= 4'hf;
      wr(8'h00, 32'h0, 2'h0);
      rdc(8'h00, 32'h0, 2'h0);
   end
   endtask
   task t_pin;
   begin
      m.pulse(1, 8);
      rdc(8'h00, 32'h0, 2'h0);
      m.pulse(1, 25);
      settle;
      near(n, SC - 1, SC + 4);
      rdc(8'h00, 32'h2, 2'h0);
      wr(8'h00, 32'h0, 2'h0);
   end
   endtask
   task t_brown;
   begin
      brownout_detector_enable <= 1'b1;
      brownout_level_select <= 1'b1;
      m.pulse(3, 30);
      m.pulse(2, 12);
      rdc(8'h00, 32'h0, 2'h0);
      m.pulse(2, 30);
      settle;
      near(n, SC - 1, SC + 4);
      rdc(8'h00, 32'h4, 2'h0);
      wr(8'h00, 32'h0, 2'h0);
      brownout_level_select <= 1'b0;
      m.pulse(3, 30);
      settle;
      rdc(8'h00, 32'h4, 2'h0);
      wr(8'h00, 32'h0, 2'h0);
      brownout_detector_enable <= 1'b0;
      m.pulse(3, 30);
      rdc(8'h00, 32'h0, 2'h0);
   end
   endtask
   task t_misc;
   begin
      debug_reset_instruction <= 1'b1;
      repeat (5) @(posedge aclk);
      rdc(8'h00, 32'h10, 2'h0);
      debug_reset_instruction <= 1'b0;
      settle;
      for (n = 0; n < 8; n = n + 1)
      begin
         {brownout_detector_enable, comparator_bandgap_select, converter_enable} <= n[2:0];
         repeat (3) @(posedge aclk);
         check(bandgap_enable_q, n != 0);
      end
      {brownout_detector_enable, comparator_bandgap_select, converter_enable} <= 3'h0;
      m.pulse(0, 5);
      settle;
      near(n, SC - 1, SC + 4);
      rdc(8'h00, 32'h1, 2'h0);
      wr(8'h00, 32'h0, 2'h0);
   end
   endtask
   task t_wdt;
   begin
      wr(8'h04, 32'h08, 2'h0);
      wr(8'h04, 32'h00, 2'h0);
      rdc(8'h08, 32'h1, 2'h0);
      wr(8'h04, 32'h18, 2'h0);
      repeat (6) @(posedge aclk);
      wr(8'h04, 32'h00, 2'h0);
      rdc(8'h04, 32'h08, 2'h0);
      wr(8'h04, 32'h18, 2'h0);
      wr(8'h04, 32'h00, 2'h0);
      rdc(8'h04, 32'h00, 2'h0);
      wr(8'h04, 32'h08, 2'h0);
      run <= 1'b1;
      repeat (3)
      begin
         repeat (16000) @(posedge aclk);
         watchdog_reset_instr <= 1'b1;
         @(posedge aclk);
         watchdog_reset_instr <= 1'b0;
      end
      check(internal_reset_q, 32'h0);
      n = 0;
      while (internal_reset_q !== 1'b1 && n < 40000)
         begin @(posedge aclk); n = n + 1; end
      near(n, 32740, 32800);
      settle;
      near(n, SC - 1, SC + 4);
      rdc(8'h00, 32'h8, 2'h0);
      wr(8'h04, 32'h18, 2'h0);
      wr(8'h04, 32'h00, 2'h0);
      wr(8'h04, 32'h07, 2'h0);
      rdc(8'h04, 32'h07, 2'h0);
      run <= 1'b0;
   end
   endtask
   initial
   begin
      errors = 0;
      checked = 0;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {debug_reset_instruction, brownout_level_select, brownout_detector_enable, run} = 0;
      {comparator_bandgap_select, converter_enable} = 0;
      watchdog_reset_instr = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_start;
      t_pin;
      t_brown;
      t_misc;
      t_wdt;
      test_done;
   end
endmodule // testbench

// ===== verilog/min_duration_filter.v
/*
 Qualifies a level: the output rises only after the input has been high for
 HOLD_CYCLES consecutive clocks and falls at once when the input drops.
 Assumes the input is synchronous to aclk.
*/
`timescale 1ns/100ps
module min_duration_filter
#(
   parameter integer HOLD_CYCLES = 15,
   parameter integer CNT_W       = 8
)
(
   input  wire       aclk,
   input  wire       aresetn,
   input  wire       level_in,
   output reg        qualified_q
);
   reg [CNT_W-1:0] count_q;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_q     <= {CNT_W{1'b0}};
         qualified_q <= 1'b0;
      end
      else if (!level_in)
      begin
         count_q     <= {CNT_W{1'b0}};
         qualified_q <= 1'b0;
      end
      else if (count_q == HOLD_CYCLES[CNT_W-1:0] - 1'b1)
         qualified_q <= 1'b1;
      else
         count_q <= count_q + 1'b1;
   end
endmodule // min_duration_filter

// ===== verilog/reset_sequencer_defines.vh
/*
 Register offsets, field positions, reset values and timing figures of the
 reset source sequencer. Definitions only; included by the sequencer design file.
*/
`ifndef RESET_SEQUENCER_DEFINES_VH
`define RESET_SEQUENCER_DEFINES_VH

// Byte offsets on the register bus
`define OFS_RESET_CAUSE      8'h00
`define OFS_WATCHDOG_CTRL    8'h04
`define OFS_SEQ_STATUS       8'h08

// Reset cause status fields
`define BIT_POWERON_FLAG     0
`define BIT_PIN_FLAG         1
`define BIT_BROWNOUT_FLAG    2
`define BIT_WATCHDOG_FLAG    3
`define BIT_DEBUG_FLAG       4
`define RESET_CAUSE_INIT     5'h01

// Watchdog control fields
`define BIT_WDT_TURNOFF      4
`define BIT_WDT_ENABLE       3
`define WDT_PERIOD_MSB       2
`define WDT_PERIOD_LSB       0
`define WDT_CTRL_INIT        5'h00
`define WDT_BASE_CYCLES      22'h004000
`define WDT_COUNT_W          22
`define WDT_TURNOFF_CLOCKS   3'h4

// Timing: clock period, least times in ns, and derived cycle counts
`define CLK_PERIOD_NS        100
`define PIN_MIN_PULSE_NS     1500
`define BROWNOUT_MIN_NS      2000
`define PIN_MIN_CYCLES       ((`PIN_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BROWNOUT_MIN_CYCLES  ((`BROWNOUT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STARTUP_CYCLES       65536

// Bus responses
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ===== verilog/reset_source_sequencer.v
/*
 Reset source sequencer: combines power-on, pin, brown-out, watchdog and
 debug reset sources into one stretched internal reset, keeps reset-cause
 flags, enables the bandgap reference and holds the watchdog timer core.
 Registers sit behind an AXI4-Lite slave. All inputs, including the watchdog
 oscillator tick, are taken as synchronous to aclk.
*/
`timescale 1ns/100ps
`include "reset_sequencer_defines.vh"

// Notes on behaviour
// - Power-on reset holds while supply is low and reasserts at once on a drop.
// - Supply reaching threshold starts the delay counter; reset holds until time-out.
// - Pin low beyond 1.5 us resets; shorter pulses need not take effect.
// - Pin release lets the delay counter run the full time-out first.
// - Level select bit: unprogrammed picks 2.7 V, programmed picks 4.0 V.
// - Enabled brown-out detector asserts reset once the supply has stayed below the trigger level for 2 us.
// - After supply recovers, release waits for the delay counter time-out.
// - Brown-out counts only when the dip outlasts 2 us.
// - Watchdog expiry gives a one-clock pulse; delay starts at its end.
// - Status bit 4 set by debug reset; cleared by power-on or writing zero.
// - Status bit 3 set by watchdog reset; cleared by power-on or writing zero.
// - Status bit 2 set by brown-out reset; cleared by power-on or writing zero.
// - Status bit 1 set by pin reset; cleared by power-on or writing zero.
// - Status bit 0 set by power-on; cleared only by software writing zero.
// - Bandgap powered only for brown-out detector, comparator select or converter.
// - Watchdog counter runs from its own oscillator tick, not the system clock.
// - Watchdog counter restarts on watchdog-reset, disable, and chip reset.
// - Eight periods; expiry without watchdog-reset resets the chip.
// - Disabling the watchdog is refused without the protected sequence.
// - Turn-off enable plus enable together, then clear enable within four clocks.
// - Period codes 000 to 111 give 16K doubling up to 2048K oscillator cycles.
// - Port reset output asserts as soon as any reset source is active.
module reset_source_sequencer
#(
   parameter integer STARTUP_CYCLES = `STARTUP_CYCLES,
   parameter integer STARTUP_W      = 17
)
(
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite slave
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Reset sources and monitors
   input  wire        supply_above_por,
   input  wire        pin_reset_n,
   input  wire        vcc_below_low_level,
   input  wire        vcc_below_high_level,
   input  wire        brownout_level_select,
   input  wire        brownout_detector_enable,
   input  wire        debug_reset_instruction,
   // Reference users and watchdog inputs
   input  wire        comparator_bandgap_select,
   input  wire        converter_enable,
   input  wire        watchdog_osc_tick,
   input  wire        watchdog_reset_instr,
   // Outputs
   output reg         internal_reset_q,
   output reg         port_reset_q,
   output reg         bandgap_enable_q
);
   reg [4:0]              cause_q;
   reg [4:0]              wdt_ctrl_q;
   reg [2:0]              turnoff_cnt_q;
   reg [`WDT_COUNT_W-1:0] wdt_count_q;
   reg                    wdt_pulse_q;
   reg [STARTUP_W-1:0]    delay_q;
   reg                    por_seen_q;
   reg [7:0]              awaddr_q;
   reg                    aw_full_q;
   reg [31:0]             wdata_q;
   reg [3:0]              wstrb_q;
   reg                    w_full_q;

   wire pin_held;
   wire bod_held;
   wire por_active   = ~supply_above_por;
   // A one in the level select is the unprogrammed state, the lower level
   wire below_level  = brownout_level_select ? vcc_below_low_level
                                             : vcc_below_high_level;
   wire bod_active   = brownout_detector_enable & bod_held;
   wire any_source   = por_active | pin_held | bod_active
                       | debug_reset_instruction | wdt_pulse_q;
   wire delay_done   = (delay_q == STARTUP_CYCLES[STARTUP_W-1:0]);

   wire wr_go   = aw_full_q & w_full_q & ~s_axi_bvalid;
   wire wr_lane = wr_go & wstrb_q[0];
   wire wr_cause = wr_lane & (awaddr_q == `OFS_RESET_CAUSE);
   wire wr_wdt   = wr_lane & (awaddr_q == `OFS_WATCHDOG_CTRL);

   wire wdt_enabled  = wdt_ctrl_q[`BIT_WDT_ENABLE];
   wire [2:0] wdt_period = wdt_ctrl_q[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB];

   // Time-out in oscillator cycles for a period code
   function [`WDT_COUNT_W-1:0] wdt_limit;
      input [2:0] code;
      begin
         wdt_limit = `WDT_BASE_CYCLES << code;
      end
   endfunction

   // Whether an address is one of ours
   function mapped;
      input [7:0] addr;
      begin
         mapped = (addr == `OFS_RESET_CAUSE) || (addr == `OFS_WATCHDOG_CTRL)
                  || (addr == `OFS_SEQ_STATUS);
      end
   endfunction

   min_duration_filter
   #(
      .HOLD_CYCLES (`PIN_MIN_CYCLES),
      .CNT_W       (8)
   )
   pin_filter
   (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .level_in    (~pin_reset_n),
      .qualified_q (pin_held)
   );

   min_duration_filter
   #(
      .HOLD_CYCLES (`BROWNOUT_MIN_CYCLES),
      .CNT_W       (8)
   )
   bod_filter
   (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .level_in    (below_level),
      .qualified_q (bod_held)
   );

   // Shared delay counter and the internal reset it stretches
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         delay_q          <= {STARTUP_W{1'b0}};
         internal_reset_q <= 1'b1;
         port_reset_q     <= 1'b1;
      end
      else
      begin
         if (any_source)
            delay_q <= {STARTUP_W{1'b0}};
         else if (!delay_done)
            delay_q <= delay_q + 1'b1;
         // Power-on drop asserts reset directly and also clears the counter
         internal_reset_q <= any_source | ~delay_done | por_active;
         port_reset_q     <= any_source;
      end
   end

   // Bandgap enable
   always @(posedge aclk)
   begin
      if (!aresetn)
         bandgap_enable_q <= 1'b0;
      else
         bandgap_enable_q <= brownout_detector_enable | comparator_bandgap_select
                             | converter_enable;
   end

   // Reset-cause flags: a set in the same cycle as a software clear wins
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cause_q    <= `RESET_CAUSE_INIT;
         por_seen_q <= 1'b1;
      end
      else
      begin
         por_seen_q <= por_active;
         if (por_active)
            cause_q <= `RESET_CAUSE_INIT;
         else
         begin
            cause_q[`BIT_POWERON_FLAG]  <= (cause_q[`BIT_POWERON_FLAG]
               & ~(wr_cause & ~wdata_q[`BIT_POWERON_FLAG])) | por_seen_q;
            cause_q[`BIT_PIN_FLAG]      <= (cause_q[`BIT_PIN_FLAG]
               & ~(wr_cause & ~wdata_q[`BIT_PIN_FLAG])) | pin_held;
            cause_q[`BIT_BROWNOUT_FLAG] <= (cause_q[`BIT_BROWNOUT_FLAG]
               & ~(wr_cause & ~wdata_q[`BIT_BROWNOUT_FLAG])) | bod_active;
            cause_q[`BIT_WATCHDOG_FLAG] <= (cause_q[`BIT_WATCHDOG_FLAG]
               & ~(wr_cause & ~wdata_q[`BIT_WATCHDOG_FLAG])) | wdt_pulse_q;
            cause_q[`BIT_DEBUG_FLAG]    <= (cause_q[`BIT_DEBUG_FLAG]
               & ~(wr_cause & ~wdata_q[`BIT_DEBUG_FLAG]))
               | debug_reset_instruction;
         end
      end
   end

   // Watchdog control with protected turn-off
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wdt_ctrl_q    <= `WDT_CTRL_INIT;
         turnoff_cnt_q <= 3'h0;
      end
      else
      begin
         if (turnoff_cnt_q != 3'h0)
            turnoff_cnt_q <= turnoff_cnt_q - 1'b1;
         if (turnoff_cnt_q == 3'h1)
            wdt_ctrl_q[`BIT_WDT_TURNOFF] <= 1'b0;
         if (wr_wdt)
         begin
            wdt_ctrl_q[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB] <=
               wdata_q[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB];
            if (wdata_q[`BIT_WDT_ENABLE])
               wdt_ctrl_q[`BIT_WDT_ENABLE] <= 1'b1;
            else if (wdt_ctrl_q[`BIT_WDT_TURNOFF])
               wdt_ctrl_q[`BIT_WDT_ENABLE] <= 1'b0;
            if (wdata_q[`BIT_WDT_TURNOFF])
            begin
               wdt_ctrl_q[`BIT_WDT_TURNOFF] <= 1'b1;
               turnoff_cnt_q <= `WDT_TURNOFF_CLOCKS;
            end
         end
      end
   end

   // Watchdog counter advances only on oscillator ticks
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wdt_count_q <= {`WDT_COUNT_W{1'b0}};
         wdt_pulse_q <= 1'b0;
      end
      else
      begin
         wdt_pulse_q <= 1'b0;
         if (watchdog_reset_instr | ~wdt_enabled | internal_reset_q)
            wdt_count_q <= {`WDT_COUNT_W{1'b0}};
         else if (watchdog_osc_tick)
         begin
            if (wdt_count_q == wdt_limit(wdt_period) - 1'b1)
            begin
               wdt_count_q <= {`WDT_COUNT_W{1'b0}};
               wdt_pulse_q <= 1'b1;
            end
            else
               wdt_count_q <= wdt_count_q + 1'b1;
         end
      end
   end

   // AXI4-Lite write channel
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid & s_axi_awready)
         begin
            awaddr_q      <= s_axi_awaddr;
            aw_full_q     <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            w_full_q     <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
         end
         if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // AXI4-Lite read channel
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `RESP_OKAY;
         s_axi_rdata   <= 32'h00000000;
      end
      else
      begin
         if (s_axi_arvalid & s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (s_axi_araddr)
               `OFS_RESET_CAUSE:   s_axi_rdata <= {27'h0, cause_q};
               `OFS_WATCHDOG_CTRL: s_axi_rdata <= {27'h0, wdt_ctrl_q};
               `OFS_SEQ_STATUS:    s_axi_rdata <= {26'h0, bandgap_enable_q,
                                      internal_reset_q, bod_active, pin_held,
                                      por_active, wdt_enabled};
               default:            s_axi_rdata <= 32'h00000000;
            endcase
         end
         if (s_axi_rvalid & s_axi_rready)
         begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // reset_source_sequencer
